// ### sfc_params.svh
// named constants of the serial flash command port
`ifndef SFC_PARAMS_SVH
`define SFC_PARAMS_SVH
`define SFC_OP_ARRAY_FAST    8'h0B
`define SFC_OP_ARRAY_SLOW    8'h03
`define SFC_OP_PAGE_READ     8'hD2
`define SFC_OP_BUF_FAST      8'hD4
`define SFC_OP_BUF_SLOW      8'hD1
`define SFC_OP_PROT_READ     8'h32
`define SFC_OP_LOCK_READ     8'h35
`define SFC_OP_SEC_READ      8'h77
`define SFC_OP_STATUS        8'hD7
`define SFC_OP_IDENT         8'h9F
`define SFC_PAGE_LONG        9'h108
`define SFC_PAGE_SHORT       9'h100
`define SFC_ADDR_BYTES       3'h3
`define SFC_BIT_LAST         3'h7
`define SFC_STAT_READY       7
`define SFC_STAT_PSIZE       0
`define SFC_ID_DEFAULT       32'h5A5A0101
`define SFC_RST_NS           10000
`define SFC_CLK_NS           20
`define SFC_HALF_DIV         4
`define SFC_REWRITE_OPS      10000
`define SFC_PAGES_PER_SECTOR 128
`endif

// ### sfc_pkg.sv
// types and opcode helpers shared by both ends of the link
package sfc_pkg;
  `include "sfc_params.svh"

  typedef enum logic [3:0] {
    DP_CMD   = 4'h1,
    DP_ADDR  = 4'h2,
    DP_DUMMY = 4'h4,
    DP_DATA  = 4'h8
  } sfc_dphase_type;

  typedef struct packed {
    sfc_dphase_type phase;
    logic [2:0]     bit_cnt;
    logic [7:0]     shin;
    logic [7:0]     opcode;
    logic [2:0]     byte_cnt;
    logic [23:0]    addr;
    logic [9:0]     page;
    logic [8:0]     offset;
    logic [1:0]     id_idx;
    logic           sync1;
    logic           page_256;
  } sfc_dev_state_type;

  typedef enum logic [5:0] {
    HS_RESET = 6'h01,
    HS_IDLE  = 6'h02,
    HS_SETUP = 6'h04,
    HS_SEL   = 6'h08,
    HS_RUN   = 6'h10,
    HS_END   = 6'h20
  } sfc_hstate_type;

  typedef struct packed {
    sfc_hstate_type state;
    logic [15:0]    div;
    logic [15:0]    rst_cnt;
    logic [19:0]    rcnt;
    logic [19:0]    ccnt;
    logic [19:0]    tot_caps;
    logic [6:0]     hdr_bits;
    logic [63:0]    hdr;
    logic [7:0]     wsh;
    logic [7:0]     rx;
    logic           sck;
    logic           cs_n;
    logic           mosi;
    logic           dev_rst;
    logic           cpol;
    logic           launch;
    logic           s1;
    logic           s2;
    logic           ready;
    logic           rd_valid;
    logic [7:0]     rd_data;
    logic           wr_take;
    logic           done;
    logic [15:0]    op_cnt;
    logic           rewrite_due;
    logic [9:0]     rewrite_page;
  } sfc_host_state_type;

  // dummy bytes between address and data
  function automatic logic [2:0] sfc_dummy_bytes(input logic [7:0] op);
    logic [2:0] n;
    n = 3'h0;
    case (op)
      `SFC_OP_ARRAY_FAST: n = 3'h1;
      `SFC_OP_BUF_FAST:   n = 3'h1;
      `SFC_OP_PAGE_READ:  n = 3'h4;
      `SFC_OP_PROT_READ:  n = 3'h3;
      `SFC_OP_LOCK_READ:  n = 3'h3;
      `SFC_OP_SEC_READ:   n = 3'h3;
      default:            n = 3'h0;
    endcase
    return n;
  endfunction

  // status and identity reads carry no address
  function automatic logic sfc_has_addr(input logic [7:0] op);
    return (op != `SFC_OP_STATUS) && (op != `SFC_OP_IDENT);
  endfunction
endpackage

// ### sfc_link_if.sv
// four-wire serial link between host and flash device, plus device reset
`timescale 1ns/1ns
interface sfc_link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic dev_rst;
  logic miso_wire;

  // pulled high while the device floats its output
  assign miso_wire = miso_oe ? miso : 1'b1;

  modport dev (
    input  sck,
    input  cs_n,
    input  mosi,
    input  dev_rst,
    output miso,
    output miso_oe
  );

  modport host (
    output sck,
    output cs_n,
    output mosi,
    output dev_rst,
    input  miso_wire
  );
endinterface

// ### sfc_dev.sv
// serial flash device end: command decode, address capture, read data out
`timescale 1ns/1ns
`include "sfc_params.svh"
module sfc_dev #(
  parameter logic [31:0] ID_CODE = `SFC_ID_DEFAULT  // arbitrary neutral value
) (
  sfc_link_if.dev lnk,
  input  wire logic       cfg_page_256,
  input  wire logic [7:0] mem_rd_data,
  output logic [7:0]      mem_cmd,
  output logic [9:0]      mem_page,
  output logic [8:0]      mem_offset,
  output logic            mem_active
);
  import sfc_pkg::*;

  // ----------------------------------------------------------------
  // state and reset
  // ----------------------------------------------------------------
  sfc_dev_state_type st;
  sfc_dev_state_type next_st;
  logic [7:0]        tx;
  logic              oe;
  logic              arst;
  logic [7:0]        byte_in;
  logic              byte_done;
  logic [23:0]       addr_full;
  logic [2:0]        dummy;
  logic [8:0]        page_size;
  logic [8:0]        off_inc;
  logic [7:0]        src;
  logic [7:0]        stat;

  // a deselect clears the whole frame; sck may stop while cs is high
  assign arst = lnk.dev_rst | lnk.cs_n;

  // ----------------------------------------------------------------
  // input side, rising edge
  // ----------------------------------------------------------------
  // the frame starts on the first rising edge in either idle level
  always_comb
  begin
    next_st = st;
    next_st.sync1 = cfg_page_256;
    next_st.page_256 = st.sync1;
    byte_in = {st.shin[6:0], lnk.mosi};
    byte_done = (st.bit_cnt == `SFC_BIT_LAST);
    addr_full = {st.addr[15:0], byte_in};
    dummy = sfc_dummy_bytes(st.opcode);
    page_size = st.page_256 ? `SFC_PAGE_SHORT : `SFC_PAGE_LONG;
    off_inc = st.offset + 9'h001;
    next_st.shin = byte_in;
    next_st.bit_cnt = st.bit_cnt + 3'h1;
    unique case (st.phase)
      DP_CMD:
      begin
        if (byte_done)
        begin
          next_st.opcode = byte_in;
          next_st.byte_cnt = 3'h0;
          next_st.page = 10'h000;
          next_st.offset = 9'h000;
          next_st.id_idx = 2'h0;
          if (sfc_has_addr(byte_in))
            next_st.phase = DP_ADDR;
          else
            next_st.phase = DP_DATA;
        end
      end
      DP_ADDR:
      begin
        if (byte_done)
        begin
          next_st.addr = addr_full;
          next_st.byte_cnt = st.byte_cnt + 3'h1;
          if (st.byte_cnt == `SFC_ADDR_BYTES - 3'h1)
          begin
            next_st.byte_cnt = 3'h0;
            // split page and byte by the configured page size
            if (st.page_256)
            begin
              next_st.page = addr_full[17:8];
              next_st.offset = {1'b0, addr_full[7:0]};
            end
            else
            begin
              next_st.page = addr_full[18:9];
              next_st.offset = addr_full[8:0];
            end
            if (dummy == 3'h0)
              next_st.phase = DP_DATA;
            else
              next_st.phase = DP_DUMMY;
          end
        end
      end
      DP_DUMMY:
      begin
        if (byte_done)
        begin
          next_st.byte_cnt = st.byte_cnt + 3'h1;
          if (st.byte_cnt == dummy - 3'h1)
            next_st.phase = DP_DATA;
        end
      end
      DP_DATA:
      begin
        // the byte was loaded on the falling edge just before this one
        if (st.bit_cnt == 3'h0)
        begin
          next_st.id_idx = st.id_idx + 2'h1;
          if (off_inc == page_size)
          begin
            next_st.offset = 9'h000;
            // only the continuous reads walk on into the next page
            if ((st.opcode == `SFC_OP_ARRAY_FAST) || (st.opcode == `SFC_OP_ARRAY_SLOW))
              next_st.page = st.page + 10'h001;
          end
          else
          begin
            next_st.offset = off_inc;
          end
        end
      end
    endcase
  end

  // state register on the link clock
  always_ff @(posedge lnk.sck or posedge arst)
  begin
    if (arst)
    begin
      st <= '{
        phase:    DP_CMD,
        bit_cnt:  3'h0,
        shin:     8'h00,
        opcode:   8'h00,
        byte_cnt: 3'h0,
        addr:     24'h000000,
        page:     10'h000,
        offset:   9'h000,
        id_idx:   2'h0,
        sync1:    1'b0,
        page_256: 1'b0
      };
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // output side, falling edge
  // ----------------------------------------------------------------
  // status byte: always ready here, page size flag in bit 0
  always_comb
  begin
    stat = 8'h00;
    stat[`SFC_STAT_READY] = 1'b1;
    stat[`SFC_STAT_PSIZE] = st.page_256;
  end

  // data source by command; memory kinds come from the backend
  always_comb
  begin
    src = mem_rd_data;
    if (st.opcode == `SFC_OP_STATUS)
    begin
      src = stat;
    end
    else if (st.opcode == `SFC_OP_IDENT)
    begin
      // identity repeats every four bytes
      unique case (st.id_idx)
        2'h0: src = ID_CODE[31:24];
        2'h1: src = ID_CODE[23:16];
        2'h2: src = ID_CODE[15:8];
        2'h3: src = ID_CODE[7:0];
      endcase
    end
  end

  // launched on the falling edge so it settles inside the low phase
  always_ff @(negedge lnk.sck or posedge arst)
  begin
    if (arst)
    begin
      tx <= 8'h00;
      oe <= 1'b0;
    end
    else if (st.phase == DP_DATA)
    begin
      oe <= 1'b1;
      if (st.bit_cnt == 3'h0)
        tx <= src;
      else
        tx <= {tx[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign lnk.miso = tx[7];
  assign lnk.miso_oe = oe;
  assign mem_cmd = st.opcode;
  assign mem_page = st.page;
  assign mem_offset = st.offset;
  assign mem_active = st.phase[3];
endmodule

// ### sfc_host.sv
// host end: generates the link clock, sends commands, collects read data
`timescale 1ns/1ns
`include "sfc_params.svh"
module sfc_host #(
  parameter int HALF_DIV = `SFC_HALF_DIV,
  parameter int RST_NS   = `SFC_RST_NS,
  parameter int CLK_NS   = `SFC_CLK_NS,
  parameter int REWRITE_OPS = `SFC_REWRITE_OPS,
  parameter int PAGES_PER_SECTOR = `SFC_PAGES_PER_SECTOR
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  sfc_link_if.host         lnk,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_opcode,
  input  wire logic [23:0] cmd_addr,
  input  wire logic [15:0] cmd_len,
  input  wire logic        cmd_mode3,
  input  wire logic        cmd_use_ptr,
  input  wire logic        cfg_page_256,
  input  wire logic [7:0]  wr_data,
  input  wire logic        op_done,
  output logic             cmd_ready,
  output logic             wr_take,
  output logic [7:0]       rd_data,
  output logic             rd_valid,
  output logic             done,
  output logic             rewrite_due,
  output logic [9:0]       rewrite_page
);
  import sfc_pkg::*;

  localparam int RST_CYC = (RST_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] DIV_LAST = 16'(HALF_DIV - 1);
  localparam logic [15:0] RST_LAST = 16'(RST_CYC - 1);
  localparam logic [15:0] OP_SPAN = 16'(REWRITE_OPS / PAGES_PER_SECTOR);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sfc_host_state_type st;
  sfc_host_state_type next_st;
  logic [23:0]        addr;
  logic [2:0]         dummy;
  logic               has_addr;
  logic               half;
  logic               fin;

  always_comb
  begin
    next_st = st;
    next_st.s1 = lnk.miso_wire;
    next_st.s2 = st.s1;
    next_st.rd_valid = 1'b0;
    next_st.wr_take = 1'b0;
    next_st.done = 1'b0;
    next_st.launch = 1'b0;
    half = (st.div == DIV_LAST);
    next_st.div = half ? 16'h0000 : st.div + 16'h0001;
    dummy = sfc_dummy_bytes(cmd_opcode);
    has_addr = sfc_has_addr(cmd_opcode);
    // rewrite address comes from the page pointer
    addr = cmd_addr;
    if (cmd_use_ptr)
      addr = cfg_page_256 ? {6'h00, st.rewrite_page, 8'h00} : {5'h00, st.rewrite_page, 9'h000};
    fin = (st.ccnt == st.tot_caps) && (st.rcnt >= {13'h0000, st.hdr_bits}) && (st.sck == st.cpol);
    unique case (st.state)
      HS_RESET:
      begin
        // select is already high here, before the reset is let go
        next_st.rst_cnt = st.rst_cnt + 16'h0001;
        if (st.rst_cnt == RST_LAST)
        begin
          next_st.dev_rst = 1'b0;
          next_st.ready = 1'b1;
          next_st.state = HS_IDLE;
        end
      end
      HS_IDLE:
      begin
        next_st.div = 16'h0000;
        if (cmd_valid)
        begin
          // any opcode goes out unchanged, so either program flow works
          next_st.hdr = has_addr ? {cmd_opcode[6:0], addr, 33'h0} : {cmd_opcode[6:0], 57'h0};
          next_st.mosi = cmd_opcode[7];
          // four-bit byte count, since a page read header is eight bytes
          next_st.hdr_bits = {4'h1 + (has_addr ? {1'b0, `SFC_ADDR_BYTES} : 4'h0) + {1'b0, dummy}, 3'h0};
          next_st.tot_caps = {1'b0, cmd_len, 3'h0};
          next_st.rcnt = 20'h00000;
          next_st.ccnt = 20'h00000;
          next_st.cpol = cmd_mode3;
          next_st.sck = cmd_mode3;
          next_st.ready = 1'b0;
          if (cmd_use_ptr)
          begin
            next_st.rewrite_page = st.rewrite_page + 10'h001;
            next_st.rewrite_due = 1'b0;
          end
          next_st.state = HS_SETUP;
        end
      end
      HS_SETUP:
      begin
        // clock level settles before select falls
        if (half)
        begin
          next_st.cs_n = 1'b0;
          next_st.state = HS_SEL;
        end
      end
      HS_SEL:
      begin
        if (half)
          next_st.state = HS_RUN;
      end
      HS_RUN:
      begin
        // launch one cycle after the rising edge, a full period ahead
        if (st.launch && (st.rcnt < ({13'h0000, st.hdr_bits} + st.tot_caps)))
        begin
          if (st.rcnt < {13'h0000, st.hdr_bits})
          begin
            next_st.mosi = st.hdr[63];
            next_st.hdr = {st.hdr[62:0], 1'b0};
          end
          else if (st.rcnt[2:0] == 3'h0)
          begin
            next_st.mosi = wr_data[7];
            next_st.wsh = {wr_data[6:0], 1'b0};
            next_st.wr_take = 1'b1;
          end
          else
          begin
            next_st.mosi = st.wsh[7];
            next_st.wsh = {st.wsh[6:0], 1'b0};
          end
        end
        else if (st.launch)
        begin
          next_st.mosi = 1'b0;
        end
        if (half)
        begin
          if (fin)
          begin
            next_st.state = HS_END;
          end
          else if (!st.sck)
          begin
            next_st.sck = 1'b1;
            next_st.rcnt = st.rcnt + 20'h00001;
            next_st.launch = 1'b1;
          end
          else
          begin
            next_st.sck = 1'b0;
            // capture the bit the device put out one falling edge ago
            if ((st.rcnt > {13'h0000, st.hdr_bits}) && (st.ccnt < st.tot_caps))
            begin
              next_st.rx = {st.rx[6:0], st.s2};
              next_st.ccnt = st.ccnt + 20'h00001;
              if (st.ccnt[2:0] == 3'h7)
              begin
                next_st.rd_data = {st.rx[6:0], st.s2};
                next_st.rd_valid = 1'b1;
              end
            end
          end
        end
      end
      HS_END:
      begin
        if (half)
        begin
          next_st.cs_n = 1'b1;
          next_st.done = 1'b1;
          next_st.ready = 1'b1;
          next_st.state = HS_IDLE;
        end
      end
    endcase
    // one page falls due every span of operations; a set beats the clear
    if (op_done)
    begin
      next_st.op_cnt = st.op_cnt + 16'h0001;
      if (st.op_cnt + 16'h0001 >= OP_SPAN)
      begin
        next_st.op_cnt = 16'h0000;
        next_st.rewrite_due = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st <= '0;
      st.state <= HS_RESET;
      st.cs_n <= 1'b1;
      st.dev_rst <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign lnk.sck = st.sck;
  assign lnk.cs_n = st.cs_n;
  assign lnk.mosi = st.mosi;
  assign lnk.dev_rst = st.dev_rst;
  assign cmd_ready = st.ready;
  assign wr_take = st.wr_take;
  assign rd_data = st.rd_data;
  assign rd_valid = st.rd_valid;
  assign done = st.done;
  assign rewrite_due = st.rewrite_due;
  assign rewrite_page = st.rewrite_page;
endmodule

// ### sfc_link_monitor.sv
// concurrent checks on the serial link between host and device ends
`timescale 1ns/1ns
module sfc_link_monitor #(
  parameter logic [31:0] ID_CODE = 32'h0  // arbitrary, must match the device
) (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic dev_rst
);
  logic       fall_seen;
  logic       mosi_f;
  logic [1:0] rise_q;
  logic [7:0] rises;
  logic [7:0] op;

  // header length in link bits; own table, not shared with the device
  function automatic logic [7:0] hdr_bits(input logic [7:0] o);
    case (o)
      8'hD7, 8'h9F: return 8'h08;
      8'h03, 8'hD1: return 8'h20;
      8'h0B, 8'hD4: return 8'h28;
      8'hD2:        return 8'h40;
      default:      return 8'h38;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // helper logic, cleared on deselect like the device itself
  // ----------------------------------------------------------------
  // values just before a fall; a rise must still see them
  always_ff @(negedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      fall_seen <= 1'b0;
      mosi_f    <= 1'b0;
    end
    else
    begin
      fall_seen <= 1'b1;
      mosi_f    <= mosi;
    end
  end

  // rise count, opcode capture and output seen before each rise
  always_ff @(posedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      rises  <= 8'h00;
      op     <= 8'h00;
      rise_q <= 2'h0;
    end
    else
    begin
      rises  <= rises + 8'h01;
      rise_q <= {miso_oe, miso};
      if (rises < 8'h08)
        op <= {op[6:0], mosi};
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  drive_fall_a: assert property (@(negedge sck) disable iff (cs_n || dev_rst)
    rises != 8'h00 |-> miso_oe == rise_q[1] && (!miso_oe || miso == rise_q[0]))
    else $error("device output moved at a rising edge");
  mosi_hold_a: assert property (@(posedge sck) disable iff (cs_n || dev_rst)
    fall_seen |-> mosi == mosi_f)
    else $error("host data moved during the clock low phase");
  data_start_a: assert property (@(posedge sck) disable iff (cs_n || dev_rst)
    $rose(miso_oe) |-> rises == hdr_bits(op))
    else $error("device output started after a wrong header length");
  status_bits_a: assert property (@(posedge sck) disable iff (cs_n || dev_rst)
    $rose(miso_oe) && op == 8'hD7 |-> miso ##1 !miso [*6])
    else $error("status byte bits wrong or out of order");
  ident_msb_a: assert property (@(posedge sck) disable iff (cs_n || dev_rst)
    $rose(miso_oe) && op == 8'h9F |-> miso == ID_CODE[31] ##1 miso == ID_CODE[30])
    else $error("identification not sent msb first");
  quiet_header_a: assert property (@(posedge sck) disable iff (cs_n || dev_rst)
    rises < 8'h08 |-> !miso_oe)
    else $error("device drove output during the opcode");
  float_desel_a: assert property (@(negedge cs_n) disable iff (dev_rst)
    !miso_oe)
    else $error("device output driven while deselected");
  reset_order_a: assert property (@(negedge dev_rst)
    cs_n)
    else $error("device reset released with select low");
endmodule

// ### tb_serial_flash_command_port.sv
// self-checking bench: host and device ends joined over the serial link
`timescale 1ns/1ns
`include "sfc_params.svh"
module tb_serial_flash_command_port;
  import sfc_pkg::*;
  localparam logic [31:0] ID_CODE = 32'hC3A51E87;  // arbitrary value
  logic        ref_clk;
  logic        rst;
  logic        cmd_valid;
  logic [7:0]  cmd_opcode;
  logic [23:0] cmd_addr;
  logic [15:0] cmd_len;
  logic        cmd_mode3;
  logic        cmd_use_ptr;
  logic        cfg_page_256;
  logic        op_done;
  logic        cmd_ready, wr_take, rd_valid, done, rewrite_due, mem_active;
  logic [7:0]  rd_data, mem_cmd, mem_rd_data;
  logic [9:0]  rewrite_page, mem_page, exp_ptr;
  logic [8:0]  mem_offset;
  logic [7:0]  got[$];
  logic [7:0]  ops[8] = '{8'h0B, 8'h03, 8'hD2, 8'hD4, 8'hD1, 8'h32, 8'h35, 8'h77};
  int          err_total;
  int          checked;
  int          takes;
  int          act_cnt;
  logic [7:0]  op_seen;

  sfc_link_if lnk ();

  sfc_host #(.RST_NS(200)) sfc_host_inst (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .lnk          (lnk),
    .cmd_valid    (cmd_valid),
    .cmd_opcode   (cmd_opcode),
    .cmd_addr     (cmd_addr),
    .cmd_len      (cmd_len),
    .cmd_mode3    (cmd_mode3),
    .cmd_use_ptr  (cmd_use_ptr),
    .cfg_page_256 (cfg_page_256),
    .wr_data      (8'hA5),
    .op_done      (op_done),
    .cmd_ready    (cmd_ready),
    .wr_take      (wr_take),
    .rd_data      (rd_data),
    .rd_valid     (rd_valid),
    .done         (done),
    .rewrite_due  (rewrite_due),
    .rewrite_page (rewrite_page)
  );

  sfc_dev #(.ID_CODE(ID_CODE)) sfc_dev_inst (
    .lnk          (lnk),
    .cfg_page_256 (cfg_page_256),
    .mem_rd_data  (mem_rd_data),
    .mem_cmd      (mem_cmd),
    .mem_page     (mem_page),
    .mem_offset   (mem_offset),
    .mem_active   (mem_active)
  );

  sfc_link_monitor #(.ID_CODE(ID_CODE)) sfc_link_monitor_inst (
    .sck     (lnk.sck),
    .cs_n    (lnk.cs_n),
    .mosi    (lnk.mosi),
    .miso    (lnk.miso),
    .miso_oe (lnk.miso_oe),
    .dev_rst (lnk.dev_rst)
  );

  // backend memory pattern: page folds into the upper nibble
  function automatic logic [7:0] mem_f(input logic [9:0] pg, input logic [8:0] of);
    return of[7:0] ^ {pg[3:0], 4'h0};
  endfunction
  assign mem_rd_data = mem_f(mem_page, mem_offset);

  // clock and stream collector
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // sampled mid-cycle, away from the edge that moves the pulses
  always @(negedge ref_clk)
  begin
    if (rd_valid === 1'b1)
    begin
      got.push_back(rd_data);
      op_seen = mem_cmd;
      if (mem_active === 1'b1)
        act_cnt++;
    end
    if (wr_take === 1'b1)
      takes++;
  end

  // ----------------------------------------------------------------
  // compare, wait and finish helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // bounded wait so a dead handshake cannot hang the run
  task automatic wait_hi(ref logic s);
    int k;
    k = 0;
    while (s !== 1'b1 && k < 8000)
    begin
      @(negedge ref_clk);
      k++;
    end
    check("handshake", 32'(s), 32'h1);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one command through the host port; expected bytes come from the address rules
  task automatic xfer(input logic [7:0] op, input logic [23:0] a, input logic [15:0] n,
                      input logic m3, input logic ptr);
    logic [9:0] pg;
    logic [8:0] of;
    logic [7:0] e;
    int         k;
    pg = cfg_page_256 ? a[17:8] : a[18:9];
    of = cfg_page_256 ? {1'b0, a[7:0]} : a[8:0];
    if (ptr)
      pg = exp_ptr;
    wait_hi(cmd_ready);
    repeat (8) @(negedge ref_clk);  // select high gap between frames
    got.delete();
    takes = 0;
    act_cnt = 0;
    op_seen = 8'h00;
    cmd_opcode = op;
    cmd_addr = a;
    cmd_len = n;
    cmd_mode3 = m3;
    cmd_use_ptr = ptr;
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    wait_hi(done);
    check("byte count", 32'(got.size()), 32'(n));
    check("take count", 32'(takes), 32'(n));
    check("latched opcode", 32'(op_seen), 32'(op));
    check("active in data", 32'(act_cnt), 32'(n));
    check("idle after frame", 32'(mem_active), 32'h0);
    for (k = 0; k < n; k++)
    begin
      if (op == `SFC_OP_STATUS)
        e = {1'b1, 6'h00, cfg_page_256};
      else if (op == `SFC_OP_IDENT)
        e = ID_CODE[31 - 8 * (k % 4) -: 8];
      else
      begin
        e = mem_f(pg, of);
        of++;
        if (of == (cfg_page_256 ? `SFC_PAGE_SHORT : `SFC_PAGE_LONG))
        begin
          of = 9'h000;
          if (op == `SFC_OP_ARRAY_FAST || op == `SFC_OP_ARRAY_SLOW)
            pg++;
        end
      end
      check("read byte", 32'(got[k]), 32'(e));
    end
  endtask

  // watchdog, well beyond the expected run length
  initial
  begin
    #1500000;
    err_total++;
    test_done();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    int i;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_opcode = 8'h00;
    cmd_addr = 24'h000000;
    cmd_len = 16'h0000;
    cmd_mode3 = 1'b0;
    cmd_use_ptr = 1'b0;
    cfg_page_256 = 1'b0;
    op_done = 1'b0;
    exp_ptr = 10'h000;
    err_total = 0;
    checked = 0;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    check("select at release", 32'(lnk.cs_n), 32'h1);
    check("device reset held", 32'(lnk.dev_rst), 32'h1);
    wait_hi(cmd_ready);
    check("device reset freed", 32'(lnk.dev_rst), 32'h0);
    $display("test reset done");
    xfer(`SFC_OP_STATUS, 24'h0, 16'h2, 1'b0, 1'b0);
    cfg_page_256 = 1'b1;
    xfer(`SFC_OP_STATUS, 24'h0, 16'h1, 1'b1, 1'b0);
    xfer(`SFC_OP_IDENT, 24'h0, 16'h5, 1'b1, 1'b0);
    $display("test status and identity done");
    // every read opcode, across the page end, both sizes and both modes
    for (i = 0; i < 8; i++)
      xfer(ops[i], 24'h0002FE, 16'h3, 1'b1, 1'b0);
    cfg_page_256 = 1'b0;
    for (i = 0; i < 8; i++)
      xfer(ops[i], 24'h000506, 16'h3, 1'b0, 1'b0);
    $display("test read opcodes done");
    // rewrite pointer: due after 78 program or erase operations
    for (i = 1; i <= 78; i++)
    begin
      op_done = 1'b1;
      @(negedge ref_clk);
      op_done = 1'b0;
      @(negedge ref_clk);
      if (i == 77)
        check("rewrite early", 32'(rewrite_due), 32'h0);
    end
    check("rewrite due", 32'(rewrite_due), 32'h1);
    check("rewrite page", 32'(rewrite_page), 32'h0);
    xfer(`SFC_OP_PAGE_READ, 24'h03FE00, 16'h2, 1'b0, 1'b1);
    exp_ptr = 10'h001;
    check("rewrite cleared", 32'(rewrite_due), 32'h0);
    check("pointer advanced", 32'(rewrite_page), 32'(exp_ptr));
    $display("test rewrite pointer done");
    test_done();
  end
endmodule
